// ===== verilog/power_selftest_fifo_regs.v
/*
 * Power, self-test, soft-reset and sample-queue register slice.
 * Assumes the serial front end decodes frames into one-cycle access strobes
 * with an address, and that the queue presents its head word with a valid.
 * An access strobe that meets burstStart is dropped, since the pointer for
 * the new transaction is loaded on that very edge.
 * Read data is registered and stands from the edge after readStrobe until
 * the next read. Pops are combinational, so the queue sees them in the
 * reading cycle.
 * Soft reset clears every register here for one cycle but leaves the pin
 * reset synchroniser and the soft reset flop alone.
 * The long settling count runs to millions of cycles; hosts poll filterSettled.
 */
`timescale 1ns/1ps
`include "accel_regs_defines.vh"
module power_selftest_fifo_regs (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Serial access strobes
  input wire burstStart,
  input wire [6:0] startAddr,
  input wire writeStrobe,
  input wire readStrobe,
  input wire [7:0] writeData,
  output reg [7:0] readData,
  output wire [6:0] currentAddr,
  // Sample queue
  input wire [15:0] queueWord,
  input wire queueValid,
  output wire queuePop,
  // Sensor controls
  output wire [1:0] operatingMode,
  output wire highpassBypass,
  output wire activityLowpassBypass,
  output wire settleShortSelect,
  output wire impactThresholdSelect,
  output wire twoWireFastSelect,
  output wire filterSettled,
  output wire selftestStimulus,
  input wire selftestResponseGood,
  output wire softResetPulse
);
  // ----------------------------------------
  // Reset synchronisation
  // ----------------------------------------
  reg rstMeta_b;
  reg rstHold_b;
  reg softReset;
  wire rstSync_b;

  // Release of rst_b passes two flops so it never lands close to an edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstHold_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstHold_b <= rstMeta_b;
    end
  end

  // soft reset joins the synchronised reset
  // The pulse lives on the pin reset alone, so the clear it causes ends cleanly
  assign rstSync_b = rstHold_b & ~softReset;

  // ----------------------------------------
  // Address pointer
  // ----------------------------------------
  reg [6:0] addr;
  reg pinned;
  reg firstAccess;
  reg [1:0] byteIndex;
  reg [15:0] heldWord;
  wire access;
  wire writeTaken;
  wire readTaken;

  // A strobe that meets burstStart is dropped: the pointer is not loaded yet
  assign writeTaken = writeStrobe & ~burstStart;
  assign readTaken = readStrobe & ~burstStart;
  assign access = readTaken | writeTaken;
  assign currentAddr = addr;

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      addr <= 7'h00;
      pinned <= 1'b0;
      firstAccess <= 1'b0;
    end else if (burstStart) begin
      addr <= startAddr;
      // pointer held for bursts from the port
      // A pinned pointer never moves, so one burst can drain the queue
      pinned <= (startAddr == `ADDR_SAMPLE_QUEUE_PORT);
      // Marks the access that lands on startAddr itself
      firstAccess <= 1'b1;
    end else if (access) begin
      firstAccess <= 1'b0;
      if (!pinned) begin
        // increment continues past the port
        // The increment wraps at the top of the 7-bit map
        addr <= addr + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Power control register
  // ----------------------------------------
  reg [7:0] powerControl;
  wire hitPower;

  assign hitPower = writeTaken && (addr == `ADDR_POWER_MODE_CONTROL);

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      powerControl <= `POWER_RESET;
    end else if (hitPower) begin
      powerControl <= writeData & `POWER_WRITE_MASK;
    end
  end

  assign operatingMode = powerControl[1:0];
  assign highpassBypass = powerControl[`BIT_HIGHPASS_BYPASS];
  assign activityLowpassBypass = powerControl[`BIT_LOWPASS_BYPASS];
  assign settleShortSelect = powerControl[`BIT_SETTLE_SHORT];
  assign impactThresholdSelect = powerControl[`BIT_IMPACT_THRESH];
  assign twoWireFastSelect = powerControl[`BIT_FAST_SELECT];

  // Settling restarts whenever the part leaves standby or the filters change outside standby
  // Threshold and speed bits do not touch the filter path, so they never restart it
  reg [7:0] powerLast;
  reg settleStart;

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      powerLast <= `POWER_RESET;
      settleStart <= 1'b0;
    end else begin
      powerLast <= powerControl;
      settleStart <= (powerControl[4:0] != powerLast[4:0]) &&
        (powerControl[1:0] != `MODE_STANDBY);
    end
  end

  // filterSettled stays low through every count and rises when the count runs out
  settle_timer #(
    .LONG_CYCLES(`SETTLE_LONG_CYCLES),
    .SHORT_CYCLES(`SETTLE_SHORT_CYCLES)
  ) settleTimer (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .start(settleStart),
    .shortSelect(settleShortSelect),
    .settled(filterSettled)
  );

  // ----------------------------------------
  // Self test
  // ----------------------------------------
  reg selftestStart;
  wire selftestDone;
  wire selftestPass;
  wire hitSelftest;

  // Only bit 0 is stored; the done and pass flags belong to the sequencer
  assign hitSelftest = writeTaken && (addr == `ADDR_SELF_TEST_CONTROL);

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      selftestStart <= 1'b0;
    end else if (hitSelftest) begin
      selftestStart <= writeData[`BIT_SELFTEST_START];
    end
  end

  // The sequencer watches for a rising start, so rewriting 1 mid-run does not restart it
  selftest_seq #(
    .RUN_CYCLES(`SELFTEST_CYCLES)
  ) selftestSeq (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .runRequest(selftestStart),
    .responseGood(selftestResponseGood),
    .stimulus(selftestStimulus),
    .done(selftestDone),
    .passed(selftestPass)
  );

  // ----------------------------------------
  // Soft reset command
  // ----------------------------------------
  wire softResetWrite;

  // Any other code written here is ignored; the register reads as zero
  assign softResetWrite = writeTaken && (addr == `ADDR_SOFT_RESET_COMMAND) && (writeData == `SOFT_RESET_CODE);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      softReset <= 1'b0;
    end else begin
      softReset <= softResetWrite;
    end
  end

  assign softResetPulse = softReset;

  // ----------------------------------------
  // Sample queue read port
  // ----------------------------------------
  wire portRead;
  wire directPortRead;
  wire popNow;

  // A pop serves three reads: high byte, low byte, then a zero filler
  assign portRead = readTaken && (addr == `ADDR_SAMPLE_QUEUE_PORT);
  assign directPortRead = portRead && (pinned || firstAccess);
  assign popNow = directPortRead && (byteIndex == 2'h0);
  // Pop needs a head word, so reading an empty queue cannot underflow it
  // one word per pop
  assign queuePop = popNow && queueValid;

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      byteIndex <= 2'h0;
      heldWord <= 16'h0000;
    end else if (burstStart) begin
      byteIndex <= 2'h0;
    end else if (directPortRead) begin
      if (popNow) begin
        // The copy feeds the low byte; an empty queue leaves it zero
        heldWord <= queueValid ? queueWord : 16'h0000;
      end
      byteIndex <= (byteIndex == 2'h2) ? 2'h0 : byteIndex + 2'h1;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Read data holds between reads so the front end may shift it out at leisure
  reg [7:0] next_readData;

  always @* begin
    next_readData = 8'h00;
    case (addr)
      `ADDR_POWER_MODE_CONTROL: begin
        next_readData = powerControl;
      end
      `ADDR_SELF_TEST_CONTROL: begin
        next_readData = {5'h00, selftestPass, selftestDone, selftestStart};
      end
      `ADDR_SAMPLE_QUEUE_PORT: begin
        if (directPortRead) begin
          case (byteIndex)
            2'h0: next_readData = queueValid ? queueWord[15:8] : 8'h00;
            2'h1: next_readData = heldWord[7:0];
            default: next_readData = 8'h00;
          endcase
        end
      end
      default: begin
        // Write-only and unmapped addresses read as zero
        next_readData = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      readData <= 8'h00;
    end else if (readTaken) begin
      readData <= next_readData;
    end
  end
endmodule

// ===== verilog/accel_regs_defines.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * power, self-test, soft-reset and sample-queue register slice.
 * Assumes a 10 MHz sample clock and an 8-bit serial register access port.
 */
`ifndef ACCEL_REGS_DEFINES_VH
`define ACCEL_REGS_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_POWER_MODE_CONTROL 7'h3f
`define ADDR_SELF_TEST_CONTROL 7'h40
`define ADDR_SOFT_RESET_COMMAND 7'h41
`define ADDR_SAMPLE_QUEUE_PORT 7'h42

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define POWER_RESET 8'h00
`define SELFTEST_RESET 8'h00
`define SOFT_RESET_CODE 8'h52

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_FAST_SELECT 7
`define BIT_IMPACT_THRESH 5
`define BIT_SETTLE_SHORT 4
`define BIT_LOWPASS_BYPASS 3
`define BIT_HIGHPASS_BYPASS 2
`define BIT_SELFTEST_PASS 2
`define BIT_SELFTEST_DONE 1
`define BIT_SELFTEST_START 0
`define POWER_WRITE_MASK 8'hbf
`define SELFTEST_WRITE_MASK 8'h01

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define MODE_STANDBY 2'h0
`define MODE_WAKEUP 2'h1
`define MODE_INSTANT_ON 2'h2
`define MODE_MEASURE 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 10000000
`define SETTLE_LONG_MS 370
`define SETTLE_SHORT_MS 16
`define SETTLE_LONG_CYCLES (`SETTLE_LONG_MS * (`CLK_HZ / 1000))
`define SETTLE_SHORT_CYCLES (`SETTLE_SHORT_MS * (`CLK_HZ / 1000))
`define SELFTEST_CYCLES 32'd20000

`endif

// ===== verilog/settle_timer.v
/*
 * Filter settling timer: counts the selected settling period after a start.
 * Assumes start is a one-cycle pulse in the sample clock domain.
 */
`timescale 1ns/1ps
`include "accel_regs_defines.vh"
module settle_timer #(
  parameter [31:0] LONG_CYCLES = `SETTLE_LONG_CYCLES,
  parameter [31:0] SHORT_CYCLES = `SETTLE_SHORT_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rstSync_b,
  // Control
  input wire start,
  input wire shortSelect,
  // Status
  output reg settled
);
  reg [31:0] count;

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count <= 32'h0000_0000;
      settled <= 1'b0;
    end else if (start) begin
      count <= shortSelect ? SHORT_CYCLES : LONG_CYCLES;
      settled <= 1'b0;
    end else if (count != 32'h0000_0000) begin
      count <= count - 32'h0000_0001;
      settled <= (count == 32'h0000_0001);
    end
  end
endmodule

// ===== verilog/selftest_seq.v
/*
 * Self-test sequencer: applies the stimulus for RUN_CYCLES while the start bit stays set, then
 * reports done and pass. Assumes the sensor core judges the response.
 */
`timescale 1ns/1ps
`include "accel_regs_defines.vh"
module selftest_seq #(
  parameter [31:0] RUN_CYCLES = `SELFTEST_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rstSync_b,
  // Control
  input wire runRequest,
  input wire responseGood,
  // Status
  output reg stimulus,
  output reg done,
  output reg passed
);
  reg [31:0] count;
  reg runLast;

  always @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      count <= 32'h0000_0000;
      runLast <= 1'b0;
      stimulus <= 1'b0;
      done <= 1'b0;
      passed <= 1'b0;
    end else begin
      runLast <= runRequest;
      if (runRequest && !runLast) begin
        stimulus <= 1'b1;
        count <= RUN_CYCLES;
        done <= 1'b0;
        passed <= 1'b0;
      end else if (!runRequest) begin
        stimulus <= 1'b0;
        count <= 32'h0000_0000;
      end else if (stimulus) begin
        count <= count - 32'h0000_0001;
        if (count == 32'h0000_0001) begin
          stimulus <= 1'b0;
          done <= 1'b1;
          passed <= responseGood;
        end
      end
    end
  end
endmodule

// ===== verif/fifo_regs_checker.sv
/* Port assertions for the register slice.
   Assumes only the slice's top ports; bound below. */
`timescale 1ns/1ps
module fifo_regs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Access
  input wire logic burstStart,
  input wire logic [6:0] startAddr,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [7:0] writeData,
  input wire logic [6:0] currentAddr,
  // Outputs
  input wire logic queuePop,
  input wire logic [1:0] operatingMode,
  input wire logic highpassBypass,
  input wire logic activityLowpassBypass,
  input wire logic settleShortSelect,
  input wire logic impactThresholdSelect,
  input wire logic twoWireFastSelect,
  input wire logic selftestStimulus,
  input wire logic softResetPulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic wa = writeStrobe && !burstStart;
  wire logic pw = wa && currentAddr == 7'h3f;
  wire logic sw = wa && currentAddr == 7'h40;
  wire logic rw = wa && currentAddr == 7'h41;
  AST_MODE: assert property (pw |=> operatingMode == $past(writeData[1:0])) else $error("mode mismatch");
  AST_BITS: assert property (pw |=> {twoWireFastSelect, impactThresholdSelect, settleShortSelect,
    activityLowpassBypass, highpassBypass} == $past({writeData[7], writeData[5:2]})) else $error("bit mismatch");
  AST_RESET: assert property ($rose(rst_b) |-> operatingMode == 2'h0 && !twoWireFastSelect) else $error("reset");
  AST_SOFT_ON: assert property (rw && writeData == 8'h52 |=> softResetPulse) else $error("no soft reset");
  AST_SOFT_OFF: assert property (rw && writeData != 8'h52 |=> !softResetPulse) else $error("bad soft reset");
  AST_STIM: assert property (sw && writeData[0] |-> ##[1:2] selftestStimulus) else $error("no stimulus");
  AST_STOP: assert property (sw && !writeData[0] |-> ##[1:2] !selftestStimulus) else $error("stimulus stuck");
  AST_POP: assert property (queuePop |-> readStrobe && currentAddr == 7'h42) else $error("stray pop");
  AST_HOLD: assert property (burstStart && startAddr == 7'h42 ##1 (readStrobe && !burstStart) [*3]
    |=> currentAddr == 7'h42) else $error("pointer moved");
  cover property (queuePop);
  cover property (softResetPulse);
  cover property (pw && writeData[1:0] == 2'h3);
endmodule

bind power_selftest_fifo_regs fifo_regs_checker chk (.clk, .rst_b, .burstStart, .startAddr, .writeStrobe,
  .readStrobe, .writeData, .currentAddr, .queuePop, .operatingMode, .highpassBypass, .activityLowpassBypass,
  .settleShortSelect, .impactThresholdSelect, .twoWireFastSelect, .selftestStimulus, .softResetPulse);

// ===== verif/sample_queue_model.sv
/* Three-entry sample queue feeding the slice.
   Assumes pops arrive as one-cycle pulses on clk. */
`timescale 1ns/1ps
module sample_queue_model (
  // Clock
  input wire logic clk,
  // Queue side
  input wire logic pop,
  output logic [15:0] word,
  output logic valid,
  // Pop count
  output int pops
);
  logic flip = 0;
  initial pops = 0;
  always @(posedge clk) begin
    flip <= ~flip;
    if (pop && valid) pops <= pops + 1;
  end
  assign valid = pops < 3;
  // Empty queue toggles so stale data cannot pass
  assign word = valid ? 16'(16'h1122 * (pops + 1)) : {16{flip}};
endmodule

// ===== verif/power_selftest_fifo_regs_tb.sv
/* Self-checking bench for the register slice.
   Assumes slice, checker and queue model compiled first. */
`timescale 1ns/1ps
module power_selftest_fifo_regs_tb;
  logic clk = 0, rst_b = 0, burstStart = 0, writeStrobe = 0, readStrobe = 0, good = 1;
  logic [6:0] startAddr = 0;
  logic [7:0] writeData = 0;
  logic [7:0] got [8];
  wire logic [7:0] readData;
  wire logic [6:0] currentAddr;
  wire logic [15:0] queueWord;
  wire logic [1:0] operatingMode;
  wire logic queueValid, queuePop, highpassBypass, activityLowpassBypass, settleShortSelect;
  wire logic impactThresholdSelect, twoWireFastSelect, selftestStimulus, filterSettled, softResetPulse;
  int pops, failures = 0, checks_done = 0;
  always #50 clk = ~clk;
  power_selftest_fifo_regs dut (.clk, .rst_b, .burstStart, .startAddr, .writeStrobe, .readStrobe, .writeData,
    .readData, .currentAddr, .queueWord, .queueValid, .queuePop, .operatingMode, .highpassBypass,
    .activityLowpassBypass, .settleShortSelect, .impactThresholdSelect, .twoWireFastSelect, .filterSettled,
    .selftestStimulus, .selftestResponseGood(good), .softResetPulse);
  sample_queue_model queue (.clk, .pop(queuePop), .word(queueWord), .valid(queueValid), .pops);

  // ---
  // Access tasks
  // ---
  task check(input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task go(input logic [6:0] a);
    @(posedge clk) #1 burstStart = 1;
    startAddr = a;
    @(posedge clk) #1 burstStart = 0;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    go(a);
    writeStrobe = 1;
    writeData = d;
    @(posedge clk) #1 writeStrobe = 0;
  endtask
  task rd(input logic [6:0] a, input int n);
    go(a);
    readStrobe = 1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1 got[i] = readData;
    end
    readStrobe = 0;
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---
  // Scenarios
  // ---
  task t_reset;
    rd(7'h3f, 1);
    check(got[0], 8'h00);
    rd(7'h40, 1);
    check(got[0], 8'h00);
    check(operatingMode, 2'h0);
    $display("reset test done");
  endtask
  task t_power;
    for (int m = 0; m < 4; m++) begin
      wr(7'h3f, (m[0] ? 8'h54 : 8'ha8) | m[7:0]);
      rd(7'h3f, 1);
      check(got[0], (m[0] ? 8'h14 : 8'ha8) | m[7:0]);
      check({twoWireFastSelect, impactThresholdSelect, settleShortSelect, activityLowpassBypass,
        highpassBypass, operatingMode}, {m[0] ? 5'h05 : 5'h1a, m[1:0]});
      check(filterSettled, 1'b0);
    end
    $display("power test done");
  endtask
  task t_incr;
    rd(7'h41, 3);
    check(got[0], 8'h00);
    check(got[1], 8'h00);
    check(pops[15:0], 16'h0000);
    check(currentAddr, 7'h44);
    $display("increment test done");
  endtask
  task t_fifo;
    logic [15:0] w;
    rd(7'h42, 7);
    for (int k = 0; k < 7; k++) begin
      w = 16'(16'h1122 * (k / 3 + 1));
      check(got[k], k % 3 == 2 ? 8'h00 : (k % 3 == 0 ? w[15:8] : w[7:0]));
    end
    check(pops[15:0], 16'h0003);
    check(currentAddr, 7'h42);
    $display("queue test done");
  endtask
  task t_soft;
    wr(7'h3f, 8'h83);
    wr(7'h41, 8'h51);
    check(softResetPulse, 1'b0);
    rd(7'h3f, 1);
    check(got[0], 8'h83);
    wr(7'h41, 8'h52);
    check(softResetPulse, 1'b1);
    repeat (4) @(posedge clk);
    rd(7'h3f, 1);
    check(got[0], 8'h00);
    check(operatingMode, 2'h0);
    $display("soft reset test done");
  endtask
  task st_run(input logic [7:0] e);
    wr(7'h40, 8'hff);
    @(posedge clk) #1;
    check(selftestStimulus, 1'b1);
    rd(7'h40, 1);
    check(got[0], 8'h01);
    // Polling read costs three cycles, so the bound covers the run time
    for (int k = 0; k < 9000 && got[0][1] !== 1'b1; k++) rd(7'h40, 1);
    if (got[0][1] !== 1'b1) begin
      failures++;
      stop_test;
    end
    check(got[0], e);
    check(selftestStimulus, 1'b0);
    wr(7'h40, 8'h00);
    rd(7'h40, 1);
    check(got[0], e & 8'hfe);
  endtask
  task t_selftest;
    // A run stopped early must drop the stimulus and report nothing
    wr(7'h40, 8'h01);
    wr(7'h40, 8'h00);
    @(posedge clk) #1;
    check(selftestStimulus, 1'b0);
    rd(7'h40, 1);
    check(got[0], 8'h00);
    st_run(8'h07);
    good = 0;
    st_run(8'h03);
    $display("self-test test done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1;
    repeat (3) @(posedge clk);
    t_reset;
    t_power;
    t_incr;
    t_fifo;
    t_soft;
    t_selftest;
    stop_test;
  end
endmodule
